// ### logic/fpm_map.svh
// timing counts, field positions and constants of the multiply unit
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

`define FPM_CLK_NS 8
`define FPM_UCYCLE_NS 200
`define FPM_INT_WAIT_UC 2
`define FPM_INT_WAIT_CYC ((`FPM_INT_WAIT_UC*`FPM_UCYCLE_NS)/`FPM_CLK_NS)

`define FPM_BIAS 10'h080
`define FPM_SIGN_BIT 31
`define FPM_EXP_HI 30
`define FPM_EXP_LO 23
`define FPM_FRAC_HI 22

`define FPM_NIB_SP 4'hE
`define FPM_NIB_SP_N 4'h6
`define FPM_NIB_DP_N 4'hE
`define FPM_NIB_INT_N 4'h8

`endif

// ### logic/fpm_pkg.sv
// types shared by the multiply unit and its users
package fpm_pkg;

   typedef enum logic [1:0] {
      FPM_OP_NONE = 2'h0,
      FPM_OP_FMUL = 2'h1,
      FPM_OP_IMUL = 2'h2
   } fpm_op_t;

   typedef struct packed {
      fpm_op_t op;
      logic dbl;
      logic spec1_reg;
      logic spec2_reg;
   } fpm_cmd_t;

   typedef struct packed {
      logic sign;
      logic [7:0] exp;
      logic [55:0] frac;
   } fpm_res_t;

   typedef enum logic [3:0] {
      FPM_S_IDLE = 4'h0,
      FPM_S_LOAD = 4'h1,
      FPM_S_CONT = 4'h3,
      FPM_S_MULW = 4'h2,
      FPM_S_NORM = 4'h6,
      FPM_S_RES = 4'h7,
      FPM_S_IWAIT = 4'hB,
      FPM_S_ILO = 4'hF,
      FPM_S_IHI = 4'hE
   } fpm_state_t;

endpackage

// ### logic/fpm_mul_unit.sv
// floating and integer longword multiply datapath with its sequencer
`timescale 1ns/10ps
`include "fpm_map.svh"

module fpm_mul_unit (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic instruction_decode_state,
   input wire fpm_pkg::fpm_cmd_t cmd,
   input wire logic [31:0] opa_bus,
   input wire logic [31:0] opb_bus,
   input wire logic ld_a,
   input wire logic ld_b,
   input wire logic ld_ext,
   input wire logic [31:0] ext_a,
   input wire logic [31:0] ext_b,
   input wire logic ops_final,
   input wire logic cpu_sync,
   output logic multiply_continue,
   output logic muldiv_complete,
   output logic res_valid,
   output fpm_pkg::fpm_res_t res_bus_a,
   output logic [31:0] int_word,
   output logic int_hi,
   output logic abort_op,
   output logic busy
);
   import fpm_pkg::*;

   localparam logic [5:0] INT_WAIT = 6'(`FPM_INT_WAIT_CYC - 1);

   fpm_state_t state_r, state_nxt;
   logic is_int_r, dbl_r;
   logic [23:0] multiplicand_fraction_reg, multiplier_fraction_reg;
   logic [31:0] multiplicand_extension_reg, multiplier_extension_reg;
   logic [31:0] integer_multiplicand_reg;
   logic [7:0] exponent_reg_a, exponent_reg_b;
   logic sign_latch_a, sign_latch_b;
   logic [63:0] product_accumulator, low_shift_register, mpl_sh_r;
   logic [63:0] normalize_register;
   logic [3:0] nib_cnt_r, nib_total;
   logic cont_ok_r, start;
   logic [9:0] exp_r;
   logic sign_r;
   logic [5:0] wait_r;
   logic [63:0] mcand, mplier, prod_top, nrm_sh;
   logic [67:0] step_sum;
   logic [3:0] nib;
   logic [56:0] rnd;
   logic zero_op, rsv_op;

   // ****************************************
   // operand registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         multiplicand_fraction_reg <= 24'h000000;
         multiplier_fraction_reg <= 24'h000000;
         multiplicand_extension_reg <= 32'h00000000;
         multiplier_extension_reg <= 32'h00000000;
         integer_multiplicand_reg <= 32'h00000000;
         exponent_reg_a <= 8'h00;
         exponent_reg_b <= 8'h00;
         sign_latch_a <= 1'b0;
         sign_latch_b <= 1'b0;
      end else if (state_r == FPM_S_IDLE && instruction_decode_state) begin
         // a register-to-register float is assumed, so every copy but multiplicand_extension_reg loads
         exponent_reg_a <= opa_bus[`FPM_EXP_HI:`FPM_EXP_LO];
         sign_latch_a <= opa_bus[`FPM_SIGN_BIT];
         multiplicand_fraction_reg <=
            {|opa_bus[`FPM_EXP_HI:`FPM_EXP_LO], opa_bus[`FPM_FRAC_HI:0]};
         exponent_reg_b <= opb_bus[`FPM_EXP_HI:`FPM_EXP_LO];
         sign_latch_b <= opb_bus[`FPM_SIGN_BIT];
         multiplier_fraction_reg <=
            {|opb_bus[`FPM_EXP_HI:`FPM_EXP_LO], opb_bus[`FPM_FRAC_HI:0]};
         multiplier_extension_reg <= opa_bus;
         integer_multiplicand_reg <= opb_bus;
      end else if (state_r == FPM_S_LOAD) begin
         if (ld_a && is_int_r) begin
            multiplier_extension_reg <= opa_bus;
         end else if (ld_a) begin
            exponent_reg_a <= opa_bus[`FPM_EXP_HI:`FPM_EXP_LO];
            sign_latch_a <= opa_bus[`FPM_SIGN_BIT];
            multiplicand_fraction_reg <=
               {|opa_bus[`FPM_EXP_HI:`FPM_EXP_LO], opa_bus[`FPM_FRAC_HI:0]};
         end
         if (ld_b && is_int_r) begin
            integer_multiplicand_reg <= opb_bus;
         end else if (ld_b) begin
            exponent_reg_b <= opb_bus[`FPM_EXP_HI:`FPM_EXP_LO];
            sign_latch_b <= opb_bus[`FPM_SIGN_BIT];
            multiplier_fraction_reg <=
               {|opb_bus[`FPM_EXP_HI:`FPM_EXP_LO], opb_bus[`FPM_FRAC_HI:0]};
         end
         if (ld_ext && dbl_r && !is_int_r) begin
            multiplicand_extension_reg <= ext_a;
            multiplier_extension_reg <= ext_b;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         is_int_r <= 1'b0;
         dbl_r <= 1'b0;
      end else if (state_r == FPM_S_IDLE && instruction_decode_state) begin
         is_int_r <= (cmd.op == FPM_OP_IMUL);
         dbl_r <= cmd.dbl && (cmd.op == FPM_OP_FMUL);
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   // minus zero is reserved; it wins over a plain zero on the other side
   assign rsv_op = (exponent_reg_a == 8'h00 && sign_latch_a) ||
                   (exponent_reg_b == 8'h00 && sign_latch_b);
   assign zero_op = (exponent_reg_a == 8'h00) || (exponent_reg_b == 8'h00);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FPM_S_IDLE: begin
            if (instruction_decode_state && cmd.op != FPM_OP_NONE) begin
               if (cmd.spec1_reg && cmd.spec2_reg &&
                   (cmd.op == FPM_OP_IMUL || !cmd.dbl)) begin
                  state_nxt = FPM_S_CONT;
               end else begin
                  state_nxt = FPM_S_LOAD;
               end
            end
         end
         FPM_S_LOAD: begin
            if (ops_final) begin
               state_nxt = FPM_S_CONT;
            end
         end
         FPM_S_CONT: begin
            if (is_int_r) begin
               state_nxt = FPM_S_IWAIT;
            end else if (rsv_op) begin
               state_nxt = FPM_S_IDLE;
            end else if (zero_op) begin
               state_nxt = FPM_S_RES;
            end else begin
               state_nxt = FPM_S_MULW;
            end
         end
         FPM_S_MULW: begin
            if (muldiv_complete) begin
               state_nxt = FPM_S_NORM;
            end
         end
         FPM_S_NORM: state_nxt = FPM_S_RES;
         FPM_S_RES: begin
            if (cpu_sync) begin
               state_nxt = FPM_S_IDLE;
            end
         end
         FPM_S_IWAIT: begin
            if (wait_r == INT_WAIT) begin
               state_nxt = FPM_S_ILO;
            end
         end
         FPM_S_ILO: begin
            if (cpu_sync) begin
               state_nxt = FPM_S_IHI;
            end
         end
         FPM_S_IHI: begin
            if (cpu_sync) begin
               state_nxt = FPM_S_IDLE;
            end
         end
         default: state_nxt = FPM_S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= FPM_S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || state_r != FPM_S_IWAIT) begin
         wait_r <= 6'h00;
      end else begin
         wait_r <= wait_r + 6'h01;
      end
   end

   // ****************************************
   // nibble multiplier
   // ****************************************
   // start in the continue state itself, where the operand registers and
   // the precision flags already hold the final operands
   assign start = (state_r == FPM_S_CONT);
   assign nib_total = is_int_r ? `FPM_NIB_INT_N :
                      (dbl_r ? `FPM_NIB_DP_N : `FPM_NIB_SP_N);

   always_comb begin
      if (is_int_r) begin
         mcand = {32'h00000000, integer_multiplicand_reg};
         mplier = {32'h00000000, multiplier_extension_reg};
      end else if (dbl_r) begin
         mcand = {8'h00, multiplicand_fraction_reg,
                  multiplicand_extension_reg};
         mplier = {8'h00, multiplier_fraction_reg, multiplier_extension_reg};
      end else begin
         mcand = {40'h0000000000, multiplicand_fraction_reg};
         mplier = {40'h0000000000, multiplier_fraction_reg};
      end
   end

   // the integer flavour is decided at decode, so no float setup is ever in flight;
   // the one start in the continue state already uses the integer registers
   assign nib = start ? mplier[3:0] : mpl_sh_r[3:0];
   assign step_sum = {4'h0, start ? 64'h0 : product_accumulator} +
                     ({4'h0, mcand} * {64'h0, nib});

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         product_accumulator <= 64'h0;
         low_shift_register <= 64'h0;
         mpl_sh_r <= 64'h0;
         nib_cnt_r <= 4'h0;
         muldiv_complete <= 1'b0;
      end else if (start) begin
         product_accumulator <= step_sum[67:4];
         low_shift_register <= {step_sum[3:0], 60'h0};
         mpl_sh_r <= {4'h0, mplier[63:4]};
         nib_cnt_r <= 4'h1;
         muldiv_complete <= 1'b0;
      end else if (cont_ok_r && nib_cnt_r != nib_total) begin
         product_accumulator <= step_sum[67:4];
         low_shift_register <= {step_sum[3:0], low_shift_register[63:4]};
         mpl_sh_r <= {4'h0, mpl_sh_r[63:4]};
         nib_cnt_r <= nib_cnt_r + 4'h1;
         muldiv_complete <= (nib_cnt_r + 4'h1 == nib_total);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || start) begin
         cont_ok_r <= 1'b0;
      end else if (multiply_continue) begin
         cont_ok_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         multiply_continue <= 1'b0;
      end else begin
         multiply_continue <= start;
      end
   end

   // ****************************************
   // exponent, sign and normalize
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         exp_r <= 10'h000;
         sign_r <= 1'b0;
      end else if (state_r == FPM_S_CONT) begin
         exp_r <= {2'h0, exponent_reg_a} + {2'h0, exponent_reg_b} -
                  `FPM_BIAS;
         sign_r <= sign_latch_a ^ sign_latch_b;
      end
   end

   assign prod_top = dbl_r ?
      {product_accumulator[55:0], low_shift_register[63:56]} :
      {product_accumulator[23:0], low_shift_register[63:56], 32'h0};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         normalize_register <= 64'h0;
      end else if (state_r == FPM_S_MULW && dbl_r) begin
         normalize_register <= prod_top;
      end else if (state_r == FPM_S_MULW && muldiv_complete) begin
         normalize_register <= prod_top;
      end
   end

   // product of two fractions in [1/2,1) is at least 1/4: one bit at most
   assign nrm_sh = normalize_register[63] ? normalize_register :
                   {normalize_register[62:0], 1'b0};
   assign rnd = {1'b0, nrm_sh[63:8]} + (dbl_r ? {56'h0, nrm_sh[7]} :
                {24'h0, nrm_sh[39], 32'h0});

   // ****************************************
   // result outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_bus_a <= '0;
      end else if (state_r == FPM_S_CONT && zero_op && !rsv_op) begin
         res_bus_a <= '0;
      end else if (state_r == FPM_S_NORM) begin
         res_bus_a.sign <= sign_r;
         res_bus_a.exp <= 8'(exp_r - {9'h0, ~normalize_register[63]} +
                          {9'h0, rnd[56]});
         if (rnd[56]) begin
            res_bus_a.frac <= {1'b1, 55'h0};
         end else if (dbl_r) begin
            res_bus_a.frac <= rnd[55:0];
         end else begin
            res_bus_a.frac <= {rnd[55:32], 32'h0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_word <= 32'h00000000;
         int_hi <= 1'b0;
      end else if (state_r == FPM_S_IWAIT && state_nxt == FPM_S_ILO) begin
         int_word <= low_shift_register[63:32];
         int_hi <= 1'b0;
      end else if (state_r == FPM_S_ILO && cpu_sync) begin
         int_word <= product_accumulator[31:0];
         int_hi <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_valid <= 1'b0;
         busy <= 1'b0;
      end else begin
         res_valid <= (state_nxt == FPM_S_RES) || (state_nxt == FPM_S_ILO) ||
                      (state_nxt == FPM_S_IHI);
         busy <= (state_nxt != FPM_S_IDLE);
      end
   end

   // abort stays up until the next decode so software-side logic sees it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         abort_op <= 1'b0;
      end else if (state_r == FPM_S_CONT && !is_int_r && rsv_op) begin
         abort_op <= 1'b1;
      end else if (instruction_decode_state) begin
         abort_op <= 1'b0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_rr_start: assert property (state_r == FPM_S_IDLE &&
      instruction_decode_state && cmd.op == FPM_OP_FMUL && !cmd.dbl &&
      cmd.spec1_reg && cmd.spec2_reg |=> state_r == FPM_S_CONT ##1
      multiply_continue)
      else $error("register float multiply did not start at once");
   chk_cont_gate: assert property (state_r == FPM_S_MULW &&
      $past(state_r) == FPM_S_MULW && $changed(nib_cnt_r) |->
      $past(cont_ok_r))
      else $error("nibble step without multiply continue");
   chk_zero_res: assert property (state_r == FPM_S_CONT &&
      !is_int_r && zero_op && !rsv_op |=> state_r == FPM_S_RES &&
      res_valid && res_bus_a == '0)
      else $error("zero operand did not give zero result");
   chk_rsv_abort: assert property (state_r == FPM_S_CONT &&
      !is_int_r && rsv_op |=> abort_op && state_r == FPM_S_IDLE && !res_valid)
      else $error("reserved operand did not abort");
   chk_dp_wait: assert property (state_r == FPM_S_MULW &&
      !muldiv_complete |=> state_r == FPM_S_MULW)
      else $error("left multiply wait before completion");
   chk_dp_fwd: assert property (state_r == FPM_S_MULW && dbl_r |=>
      normalize_register == $past(prod_top))
      else $error("double product not forwarded to normalizer");
   chk_exp_bias: assert property (state_r == FPM_S_CONT |=>
      exp_r == ($past({2'h0, exponent_reg_a}) + $past({2'h0, exponent_reg_b})
      - 10'h080))
      else $error("exponent bias wrong");
   chk_sign_xor: assert property ($past(state_r) == FPM_S_NORM |->
      res_bus_a.sign == (sign_latch_a ^ sign_latch_b) && res_bus_a.frac[55])
      else $error("product sign or normalize wrong");
   chk_int_wait: assert property (state_r == FPM_S_CONT &&
      is_int_r |-> ##51 state_r == FPM_S_ILO && res_valid && !int_hi)
      else $error("integer product not ready after two microcycles");
   chk_int_order: assert property (state_r == FPM_S_ILO &&
      cpu_sync |=> int_hi && int_word == product_accumulator[31:0])
      else $error("high word not presented after cpu sync");

   cov_int_mul: cover property (state_r == FPM_S_IHI && cpu_sync);
   cov_zero: cover property (state_r == FPM_S_CONT && zero_op && !is_int_r);
   cov_abort: cover property (state_r == FPM_S_CONT && rsv_op && !is_int_r);
   cov_dp_norm: cover property (state_r == FPM_S_NORM && dbl_r);

endmodule // fpm_mul_unit

// ### tb/fpm_host_model.sv
// host data path model that stores returned result words
`timescale 1ns/10ps

module fpm_host_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic res_valid,
   input wire logic [1:0] lat,
   output logic cpu_sync
);
   // ****************************************
   // store handshake
   // ****************************************
   logic [1:0] wait_r;

   // one pulse per presented word; a level held on would also
   // acknowledge the high word before it was stored
   always @(negedge clk) begin
      if (sys_rst || !res_valid || cpu_sync) begin
         cpu_sync <= 1'b0;
         wait_r <= 2'h0;
      end else if (wait_r >= lat) begin
         cpu_sync <= 1'b1;
      end else begin
         wait_r <= wait_r + 2'h1;
      end
   end
endmodule // fpm_host_model

// ### tb/fpm_mul_unit_test.sv
// self-checking bench of the multiply unit against a host model
`timescale 1ns/10ps
`include "fpm_map.svh"

module fpm_mul_unit_test;
   import fpm_pkg::*;
   typedef struct packed {
      logic [1:0] kind;
      logic [64:0] val;
   } fpm_note_t;
   logic clk, sys_rst, dec, ld_a, ld_b, ld_ext, ops_final, cpu_sync;
   fpm_cmd_t cmd;
   logic [31:0] opa, opb, ext_a, ext_b, int_word, seed;
   logic multiply_continue, muldiv_complete, res_valid, int_hi;
   logic abort_op, busy, seen;
   logic [1:0] lat;
   fpm_res_t res_bus_a;
   fpm_note_t notes[$];
   fpm_note_t nt;
   int num_errors, n_checks, cyc, mc_cnt, mc_cyc;

   fpm_mul_unit u_dut (.clk(clk), .sys_rst(sys_rst),
      .instruction_decode_state(dec), .cmd(cmd), .opa_bus(opa),
      .opb_bus(opb), .ld_a(ld_a), .ld_b(ld_b), .ld_ext(ld_ext),
      .ext_a(ext_a), .ext_b(ext_b), .ops_final(ops_final),
      .cpu_sync(cpu_sync), .multiply_continue(multiply_continue),
      .muldiv_complete(muldiv_complete), .res_valid(res_valid),
      .res_bus_a(res_bus_a), .int_word(int_word), .int_hi(int_hi),
      .abort_op(abort_op), .busy(busy));
   fpm_host_model u_host (.clk(clk), .sys_rst(sys_rst),
      .res_valid(res_valid), .lat(lat), .cpu_sync(cpu_sync));

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [64:0] got, input logic [64:0] want);
      n_checks++;
      if (got !== want) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, want);
      end
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // rounding after the shift; truncated exponent, as the unit does
   function automatic logic [64:0] fexp(input logic [31:0] a, b, xa, xb,
      input logic dbl);
      logic [55:0] ma, mb, fr;
      logic [112:0] p;
      logic [9:0] e;
      ma = {1'b1, a[22:0], dbl ? xa : 32'h0};
      mb = {1'b1, b[22:0], dbl ? xb : 32'h0};
      p = ma * mb;
      e = a[30:23] + b[30:23] - `FPM_BIAS;
      if (!p[111]) begin
         p = p << 1;
         e = e - 10'h001;
      end
      p = p + (dbl ? (113'h1 << 55) : (113'h1 << 87));
      if (p[112]) begin
         p = p >> 1;
         e = e + 10'h001;
      end
      fr = dbl ? p[111:56] : {p[111:88], 32'h0};
      return {a[31] ^ b[31], e[7:0], fr};
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic end_test(input string s);
      $display("test %s done at %0t", s, $time);
   endtask

   // one operation from decode to the host taking its last word
   task automatic run_op(input fpm_op_t op, input logic d, input logic rr,
      input logic [31:0] a, b, xa, xb);
      logic [63:0] p;
      logic ld, full;
      p = {32'h0, a} * {32'h0, b};
      ld = !rr || (d && op == FPM_OP_FMUL);
      full = 1'b1;
      while (busy) begin
         @(negedge clk);
      end
      if (op == FPM_OP_IMUL) begin
         notes.push_back({2'h1, 33'h0, p[31:0]});
         notes.push_back({2'h2, 32'h0, 1'b1, p[63:32]});
      end else if ((a[30:23] == 8'h00 && a[31]) ||
                   (b[30:23] == 8'h00 && b[31])) begin
         notes.push_back({2'h3, 65'h1});
         full = 1'b0;
      end else if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
         notes.push_back({2'h0, 65'h0});
         full = 1'b0;
      end else begin
         notes.push_back({2'h0, fexp(a, b, xa, xb, d)});
      end
      mc_cyc++;
      lat = 2'(rnd());
      dec = 1'b1;
      cmd.op = op;
      cmd.dbl = d;
      cmd.spec1_reg = rr;
      cmd.spec2_reg = rr;
      opa = ld ? rnd() : a;
      opb = ld ? rnd() : b;
      @(negedge clk);
      dec = 1'b0;
      check({64'h0, busy}, 65'h1);
      if (ld) begin
         opa = a;
         opb = b;
         ext_a = xa;
         ext_b = xb;
         ld_a = 1'b1;
         ld_b = 1'b1;
         ld_ext = d;
         @(negedge clk);
         ld_a = 1'b0;
         ld_b = 1'b0;
         ld_ext = 1'b0;
         ops_final = 1'b1;
         @(negedge clk);
         ops_final = 1'b0;
      end
      @(negedge clk);
      check({64'h0, multiply_continue}, 65'h1);
      while (busy) begin
         @(negedge clk);
      end
      if (full) begin
         check({64'h0, muldiv_complete}, 65'h1);
      end
   endtask

   // ****************************************
   // clock, watchdog and result monitor
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ceiling well above 47 operations of about 60 cycles each
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end

   // every accepted word retires the oldest note; an abort retires one too
   always @(posedge clk) begin
      if (!sys_rst && multiply_continue) begin
         mc_cnt++;
      end
      if (!sys_rst && ((res_valid && cpu_sync) || (abort_op && !seen))) begin
         if (notes.size() == 0) begin
            check(65'h1, 65'h0);
         end else begin
            nt = notes.pop_front();
            if (nt.kind == 2'h0) begin
               check(res_bus_a, nt.val);
            end else if (nt.kind == 2'h3) begin
               check({64'h0, abort_op}, nt.val);
            end else begin
               check({32'h0, int_hi, int_word}, nt.val);
            end
         end
      end
      seen <= abort_op;
   end

   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      logic [31:0] r;
      seed = 32'h6bc5;
      sys_rst = 1'b1;
      dec = 1'b0;
      ld_a = 1'b0;
      ld_b = 1'b0;
      ld_ext = 1'b0;
      ops_final = 1'b0;
      cmd = '0;
      opa = 32'h00000000;
      opb = 32'h00000000;
      ext_a = 32'h00000000;
      ext_b = 32'h00000000;
      lat = 2'h0;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      run_op(FPM_OP_FMUL, 1'b0, 1'b1, 32'h40C00000, 32'h40A00000,
         32'h0, 32'h0);
      run_op(FPM_OP_FMUL, 1'b0, 1'b0, 32'hC0F00001, 32'h40FFFFFF,
         32'h0, 32'h0);
      run_op(FPM_OP_FMUL, 1'b1, 1'b1, 32'h41123456, 32'h3FFEDCBA,
         32'h89ABCDEF, 32'hFFFFFFFF);
      end_test("float");
      run_op(FPM_OP_FMUL, 1'b0, 1'b1, 32'h00000000, 32'h40A00000,
         32'h0, 32'h0);
      run_op(FPM_OP_FMUL, 1'b1, 1'b0, 32'h40A00000, 32'h80000000,
         32'h0, 32'h0);
      end_test("zero and reserved");
      run_op(FPM_OP_IMUL, 1'b0, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF,
         32'h0, 32'h0);
      run_op(FPM_OP_IMUL, 1'b0, 1'b0, 32'h12345678, 32'h9ABCDEF0,
         32'h0, 32'h0);
      end_test("integer");
      repeat (40) begin
         r = rnd();
         run_op(r[0] ? FPM_OP_IMUL : FPM_OP_FMUL, r[1], r[2], rnd(), rnd(),
            rnd(), rnd());
      end
      end_test("random");
      repeat (4) @(negedge clk);
      check(65'(notes.size()), 65'h0);
      check(65'(mc_cnt), 65'(mc_cyc));
      final_report();
   end
endmodule // fpm_mul_unit_test
